/* File: hdl/fper_ctrl.sv */
// flash page erase and read controller with apb control and data read port
// ************************************************************
// operation notes
// ************************************************************
// register map, byte offsets on the apb side:
//   status 0x000: busy code in bits 1:0, read ok bit 2, erase ok bit 3
//   ctrl 0x004: reads back the latched erase word address
//   erase 0x008: write a word address to start a page erase
//   prot 0x00C: one protection bit per 512-word sector, set at reset
//   cfg 0x010: bit 0 serial, bit 1 wrap, bit 2 wide internal bus
// any other offset answers with pslverr; writes there are dropped
//
// apb timing:
//   zero wait states, pready tied high
//   read data captured in the setup cycle, held through access
//   writes land at the edge that sees psel and penable high
//   cfg writes ignored while busy so a burst never changes mode
//   prot writes accepted at any time; they only gate later work
//
// erase flow:
//   a write to the erase offset while idle latches the location
//   the location is judged legal at that edge and the verdict kept
//   legal: upper data bits zero and the sector unprotected
//   the busy code shows 01 for the whole erase
//   a legal erase runs for ERASE_CYCLES clocks, an illegal one for one
//   at the end the erase ok flag takes the kept verdict
//   only a legal erase fills its 256-word page with ones
//   writes to the erase offset while busy vanish without trace
//
// data port timing, one command at a time:
//   edge 0: read seen with waitrequest low, command taken
//   edge 1: busy code 11, waitrequest high, first word fetched
//   edge 2: first word stands on readdata with readdatavalid
//   one word per clock after that, no gaps inside a burst
//   waitrequest drops together with the last valid word
//   an erase write in the same cycle as a read wins; the read is dropped although waitrequest is low
//
// burst length checks:
//   incrementing: 1 to 128 words
//   single word: 1 in parallel mode, 32 in serial mode
//   wrapping: exactly 2 on the narrow bus, 4 on the wide bus
//   burstcount 0 is served as one word and flagged bad
//   a bad length or a protected sector gives all-ones words
//   and clears read ok; a good burst sets it
//
// address sequencing:
//   incrementing bursts roll from the top word back to word 0
//   wrapping bursts keep the upper bits and step the low one or two
//   the wrap mask is taken at command time from the bus width bit
//   serial mode forces incrementing whatever the wrap bit says
//
// reset state:
//   all sectors protected so software must open one deliberately
//   busy code idle, both success flags low, cfg cleared
//   readdatavalid and waitrequest low
//
// hazards:
//   protection is read live when a read is taken, not per word
//   a prot write during a burst does not stop that burst
//   the erase verdict is frozen at the start for the same reason
//   ctrl and erase offsets share one read value on purpose
//
// limitations:
//   no program operation and no sector erase in this block
//   array content is unknown until a page has been erased
//   the array has no reset, as a real flash keeps its content
//   erase time counts clocks; retune ERASE_CYCLES for another clock
//   one outstanding command only, no pipelining of reads
//   illegal state codes fall back to idle on the next edge
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "fper_defs.svh"

module fper_ctrl #(
  parameter int unsigned ERASE_CYCLES = `FPER_ERASE_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb control slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // data read port
  input wire fper_pkg::fper_cmd_t cmd,
  output logic waitrequest,
  output fper_pkg::fper_rsp_t rsp
);

  // ************************************************************
  // storage and registers
  // ************************************************************
  logic [31:0] mem_q [0:`FPER_WORDS-1];
  fper_pkg::fper_state_t state_reg;
  logic [`FPER_SECTORS-1:0] prot_reg;
  logic [2:0] cfg_reg;
  logic rd_ok_reg;
  logic er_ok_reg;
  logic [`FPER_AW-1:0] er_addr_reg;
  logic [31:0] er_cnt_reg;
  logic er_legal_reg;
  logic [`FPER_AW-1:0] rd_addr_reg;
  logic [`FPER_BC_W-1:0] rd_left_reg;
  logic rd_wrap_reg;
  logic rd_bad_reg;
  logic [1:0] rd_mask_reg;
  logic [31:0] rdata_reg;
  logic rvalid_reg;
  logic [31:0] prdata_reg;
  logic [`FPER_PAGES-1:0] erase_idx;

  // ************************************************************
  // apb decode
  // ************************************************************
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite;
  wire hit_status = paddr == `FPER_OFS_STATUS;
  wire hit_ctrl = paddr == `FPER_OFS_CTRL;
  wire hit_erase = paddr == `FPER_OFS_ERASE;
  wire hit_prot = paddr == `FPER_OFS_PROT;
  wire hit_cfg = paddr == `FPER_OFS_CFG;
  wire hit_any = hit_status | hit_ctrl | hit_erase | hit_prot | hit_cfg;
  wire is_idle = state_reg == fper_pkg::FPER_IDLE;
  wire serial = cfg_reg[`FPER_CFG_SERIAL];
  wire wide = cfg_reg[`FPER_CFG_WIDE];
  // wrapping is a parallel-only mode
  wire wrap_mode = cfg_reg[`FPER_CFG_WRAP] & ~serial;

  // erase request: write to erase register, accepted only when idle
  wire erase_req = apb_wr & hit_erase & is_idle;
  wire [`FPER_AW-1:0] er_word = pwdata[`FPER_AW-1:0];
  wire er_legal = (pwdata[31:`FPER_AW] == 20'h00000)
                  & ~prot_reg[er_word[`FPER_AW-1:`FPER_SECT_BITS]];
  wire erase_done = (state_reg == fper_pkg::FPER_ERASE) & (er_cnt_reg == 32'h00000000);

  // ************************************************************
  // read command decode
  // ************************************************************
  wire [`FPER_BC_W-1:0] wrap_len = wide ? `FPER_WRAP_WIDE : `FPER_WRAP_NARROW;
  wire bc_ok_inc = (cmd.burstcount != 8'h00) & (cmd.burstcount <= `FPER_BURST_TOP);
  wire bc_ok_single = serial ? (cmd.burstcount == `FPER_BC_SINGLE_SER)
                             : (cmd.burstcount == `FPER_BC_SINGLE_PAR);
  wire bc_ok = wrap_mode ? (cmd.burstcount == wrap_len) : (bc_ok_inc | bc_ok_single);
  wire sect_prot = prot_reg[cmd.address[`FPER_AW-1:`FPER_SECT_BITS]];
  wire rd_fail = ~bc_ok | sect_prot;
  wire rd_start = cmd.read & ~waitrequest;
  // erase or running burst both hold off new commands
  assign waitrequest = ~is_idle;

  // next address: increment, or wrap inside the aligned group
  wire [`FPER_AW-1:0] addr_inc = rd_addr_reg + 12'h001;
  wire [`FPER_AW-1:0] addr_wrap = {rd_addr_reg[`FPER_AW-1:2],
                                   (rd_addr_reg[1:0] + 2'h1) & rd_mask_reg |
                                   rd_addr_reg[1:0] & ~rd_mask_reg};
  wire [`FPER_AW-1:0] addr_nx = rd_wrap_reg ? addr_wrap : addr_inc;

  // ************************************************************
  // control state machine
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= fper_pkg::FPER_IDLE;
    end else begin
      unique case (state_reg)
        fper_pkg::FPER_IDLE: begin
          if (erase_req) begin
            state_reg <= fper_pkg::FPER_ERASE;
          end else if (rd_start) begin
            state_reg <= fper_pkg::FPER_READ;
          end
        end
        fper_pkg::FPER_ERASE: begin
          if (erase_done) begin
            state_reg <= fper_pkg::FPER_IDLE;
          end
        end
        fper_pkg::FPER_READ: begin
          if (rd_left_reg == 8'h01) begin
            state_reg <= fper_pkg::FPER_IDLE;
          end
        end
        default: begin
          state_reg <= fper_pkg::FPER_IDLE;
        end
      endcase
    end
  end

  // erase timer and latched location
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      er_addr_reg <= 12'h000;
      er_cnt_reg <= 32'h00000000;
      er_legal_reg <= 1'b0;
    end else if (erase_req) begin
      er_addr_reg <= er_word;
      er_legal_reg <= er_legal;
      er_cnt_reg <= er_legal ? ERASE_CYCLES - 32'h00000001 : 32'h00000000;
    end else if (er_cnt_reg != 32'h00000000) begin
      er_cnt_reg <= er_cnt_reg - 32'h00000001;
    end
  end

  // erase outcome flag; illegal location reports failure at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      er_ok_reg <= 1'b0;
    end else if (erase_req) begin
      er_ok_reg <= 1'b0;
    end else if (erase_done) begin
      er_ok_reg <= er_legal_reg;
    end
  end

  // ************************************************************
  // read engine
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_addr_reg <= 12'h000;
      rd_left_reg <= 8'h00;
      rd_wrap_reg <= 1'b0;
      rd_bad_reg <= 1'b0;
      rd_mask_reg <= 2'h0;
    end else if (rd_start & ~erase_req) begin
      rd_addr_reg <= cmd.address;
      rd_left_reg <= cmd.burstcount == 8'h00 ? 8'h01 : cmd.burstcount;
      rd_wrap_reg <= wrap_mode;
      rd_bad_reg <= rd_fail;
      rd_mask_reg <= wide ? 2'h3 : 2'h1;
    end else if (state_reg == fper_pkg::FPER_READ) begin
      rd_addr_reg <= addr_nx;
      rd_left_reg <= rd_left_reg - 8'h01;
    end
  end

  // one 32-bit word per beat; failed reads see erased (all ones) content
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= `FPER_ZERO32;
      rvalid_reg <= 1'b0;
      rd_ok_reg <= 1'b0;
    end else begin
      rvalid_reg <= state_reg == fper_pkg::FPER_READ;
      if (state_reg == fper_pkg::FPER_READ) begin
        rdata_reg <= rd_bad_reg ? `FPER_ERASED_WORD : mem_q[rd_addr_reg];
        rd_ok_reg <= ~rd_bad_reg;
      end
    end
  end
  assign rsp.readdatavalid = rvalid_reg;
  assign rsp.readdata = rdata_reg;

  // ************************************************************
  // flash array: page erase fills a page with ones
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < `FPER_PAGES; g++) begin : g_page
      assign erase_idx[g] = erase_done & er_legal_reg
                            & (er_addr_reg[`FPER_AW-1:`FPER_PAGE_BITS] == 4'(g));
    end
  endgenerate

  // no reset on the array: it models non-volatile content
  always_ff @(posedge pclk) begin
    for (int i = 0; i < `FPER_WORDS; i++) begin
      if (erase_idx[i >> `FPER_PAGE_BITS]) begin
        mem_q[i] <= `FPER_ERASED_WORD;
      end
    end
  end

  // ************************************************************
  // apb registers
  // ************************************************************
  // protection set at reset so the master must clear it first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_reg <= 8'hFF;
      cfg_reg <= 3'h0;
    end else if (apb_wr & hit_prot) begin
      prot_reg <= pwdata[`FPER_SECTORS-1:0];
    end else if (apb_wr & hit_cfg & is_idle) begin
      cfg_reg <= pwdata[2:0];
    end
  end

  wire [31:0] status_word = {28'h0000000, er_ok_reg, rd_ok_reg, state_reg};
  wire [31:0] rd_mux = hit_status ? status_word :
                       hit_ctrl ? {20'h00000, er_addr_reg} :
                       hit_erase ? {20'h00000, er_addr_reg} :
                       hit_prot ? {24'h000000, prot_reg} :
                       hit_cfg ? {29'h00000000, cfg_reg} : `FPER_ZERO32;

  // read data captured in setup so it is stable in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= `FPER_ZERO32;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_reg <= rd_mux;
    end
  end
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = apb_acc & ~hit_any;

endmodule : fper_ctrl
`default_nettype wire

/* File: hdl/fper_defs.svh */
// constants for the flash page erase and read controller
`ifndef FPER_DEFS_SVH
`define FPER_DEFS_SVH

// apb register byte offsets
`define FPER_OFS_STATUS 12'h000
`define FPER_OFS_CTRL 12'h004
`define FPER_OFS_ERASE 12'h008
`define FPER_OFS_PROT 12'h00C
`define FPER_OFS_CFG 12'h010

// status field positions
`define FPER_ST_BUSY_LO 0
`define FPER_ST_BUSY_HI 1
`define FPER_ST_RD_OK 2
`define FPER_ST_ER_OK 3

// config field positions
`define FPER_CFG_SERIAL 0
`define FPER_CFG_WRAP 1
`define FPER_CFG_WIDE 2

// busy codes
`define FPER_BUSY_IDLE 2'h0
`define FPER_BUSY_ERASE 2'h1
`define FPER_BUSY_READ 2'h3

// flash geometry: word address width, page = 256 words, 8 sectors
`define FPER_AW 12
`define FPER_WORDS 4096
`define FPER_PAGE_BITS 8
`define FPER_PAGES 16
`define FPER_SECT_BITS 9
`define FPER_SECTORS 8

// burst figures
`define FPER_BC_W 8
`define FPER_BURST_TOP 8'h80
`define FPER_BC_SINGLE_PAR 8'h01
`define FPER_BC_SINGLE_SER 8'h20
`define FPER_WRAP_NARROW 8'h02
`define FPER_WRAP_WIDE 8'h04

// erase time, 350 ms at 50 MHz
`define FPER_ERASE_MS 350
`define FPER_CLK_MHZ 50
`define FPER_ERASE_CYC (`FPER_ERASE_MS * 1000 * `FPER_CLK_MHZ)

`define FPER_ERASED_WORD 32'hFFFFFFFF
`define FPER_ZERO32 32'h00000000
`endif

/* File: hdl/fper_pkg.sv */
// types for the flash page erase and read controller
package fper_pkg;
  typedef enum logic [1:0] {
    FPER_IDLE = 2'b00,
    FPER_ERASE = 2'b01,
    FPER_READ = 2'b11
  } fper_state_t;

  typedef struct packed {
    logic read;
    logic [11:0] address;
    logic [7:0] burstcount;
  } fper_cmd_t;

  typedef struct packed {
    logic readdatavalid;
    logic [31:0] readdata;
  } fper_rsp_t;
endpackage : fper_pkg

/* File: test/fper_ctrl_asserts.sv */
// port checker for the flash page erase and read controller
`timescale 1ns/1ps
`default_nettype none
module fper_ctrl_asserts (
  // clock, reset and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // data port
  input wire fper_pkg::fper_cmd_t cmd,
  input wire logic waitrequest,
  input wire fper_pkg::fper_rsp_t rsp
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // erase write and accepted read; an erase write wins the same edge
  wire logic ew = psel && penable && pwrite && paddr == 12'h008;
  wire logic take = cmd.read && !waitrequest && !ew;
  wire logic mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
  a_pready_high: assert property (pready)
    else $error("pready low");
  a_slverr_unmapped: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  a_slverr_mapped: assert property (psel && penable && mapped |-> !pslverr)
    else $error("error on mapped access");
  a_erase_stall: assert property (ew && !waitrequest |=> waitrequest)
    else $error("erase does not stall data port");
  a_take_wait: assert property (take |=> waitrequest)
    else $error("waitrequest low after take");
  a_first_beat: assert property (take |=> !rsp.readdatavalid ##1 rsp.readdatavalid)
    else $error("first word not two edges after take");
  a_single_beat: assert property (take && cmd.burstcount == 8'h01 |=> ##1 rsp.readdatavalid ##1 !rsp.readdatavalid)
    else $error("single read not one word");
  a_beat_busy: assert property (rsp.readdatavalid |-> $past(waitrequest))
    else $error("word outside a read");
  a_busy_code: assert property (psel && !penable && !pwrite && paddr == 12'h000 && waitrequest |=> prdata[1:0] != 2'b00)
    else $error("busy field idle while busy");
  // main scenarios reached
  c_long_burst: cover property (take && cmd.burstcount == 8'h80);
  c_erase: cover property (ew && !waitrequest);
  c_unmapped: cover property (psel && penable && pslverr);
endmodule : fper_ctrl_asserts
`default_nettype wire

/* File: test/fper_master.sv */
// data port master model that issues reads and tallies words
`timescale 1ns/1ps
`default_nettype none
module fper_master (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench request
  input wire logic go,
  input wire logic [11:0] addr,
  input wire logic [7:0] count,
  // data port
  input wire logic waitrequest,
  input wire fper_pkg::fper_rsp_t rsp,
  output fper_pkg::fper_cmd_t cmd,
  output logic [8:0] nbeat,
  output logic all_ones
);
  // hold until taken, then flip released lines so stale values never match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= '0;
    end else if (go) begin
      cmd <= '{read: 1'b1, address: addr, burstcount: count};
    end else if (cmd.read && !waitrequest) begin
      cmd <= ~cmd;
    end
  end
  // tally returned words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nbeat <= 9'h000;
      all_ones <= 1'b1;
    end else if (go) begin
      nbeat <= 9'h000;
      all_ones <= 1'b1;
    end else if (rsp.readdatavalid) begin
      nbeat <= nbeat + 9'h001;
      all_ones <= all_ones & (rsp.readdata === 32'hFFFFFFFF);
    end
  end
endmodule : fper_master
`default_nettype wire

/* File: test/fper_ctrl_tb.sv */
// self-checking bench for the flash page erase and read controller
`timescale 1ns/1ps
`default_nettype none
module fper_ctrl_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [11:0] paddr = 12'h000, m_addr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, st;
  logic [7:0] m_count = 8'h01;
  logic pready, pslverr, waitrequest, all_ones, err;
  logic [8:0] nbeat;
  int n_mismatch = 0;
  int num_checks = 0;
  fper_pkg::fper_cmd_t cmd;
  fper_pkg::fper_rsp_t rsp;
  always #10 pclk = ~pclk;
  fper_ctrl #(.ERASE_CYCLES(20)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd(cmd), .waitrequest(waitrequest), .rsp(rsp));
  fper_master i_master (.pclk(pclk), .presetn(presetn), .go(go), .addr(m_addr),
    .count(m_count), .waitrequest(waitrequest), .rsp(rsp), .cmd(cmd), .nbeat(nbeat),
    .all_ones(all_ones));
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one apb transfer; reply taken at the edge that sees pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    st = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [11:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask : rd
  task start_read(input logic [11:0] a, input logic [7:0] n);
    @(posedge pclk);
    go <= 1'b1;
    m_addr <= a;
    m_count <= n;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
  endtask : start_read
  // read a burst and judge count, content and read-success flag
  task rd_burst(input logic [11:0] a, input logic [7:0] n, input logic ok);
    int k;
    k = 0;
    start_read(a, n);
    while (nbeat !== {1'b0, n} && k < 400) begin
      @(posedge pclk);
      k++;
    end
    repeat (3) @(posedge pclk);
    chk("beats", {23'h000000, nbeat}, {24'h000000, n});
    chk("ones", {31'h00000000, all_ones}, 32'h00000001);
    rd(12'h000);
    chk("read ok", {31'h00000000, st[2]}, {31'h00000000, ok});
  endtask : rd_burst
  task poll_idle;
    int k;
    k = 0;
    do begin
      rd(12'h000);
      k++;
    end while (st[1:0] !== 2'b00 && k < 100);
  endtask : poll_idle
  task t_reset;
    rd(12'h00C);
    chk("prot", st, 32'h000000FF);
    rd(12'h020);
    chk("slverr", {31'h00000000, err}, 32'h00000001);
  endtask : t_reset
  // erase page 0 with a read stalled behind it, then a bad location
  task t_erase;
    apb(1'b1, 12'h00C, 32'h000000FE);
    apb(1'b1, 12'h008, 32'h00000000);
    start_read(12'h005, 8'h01);
    rd(12'h000);
    chk("busy erase", st, 32'h00000001);
    apb(1'b1, 12'h008, 32'h00000100);
    rd(12'h004);
    chk("erase addr", st, 32'h00000000);
    chk("stalled", {23'h000000, nbeat}, 32'h00000000);
    poll_idle;
    chk("status", st, 32'h0000000C);
    chk("single", {23'h000000, nbeat}, 32'h00000001);
    apb(1'b1, 12'h008, 32'h00001000);
    poll_idle;
    chk("erase ok", {31'h00000000, st[3]}, 32'h00000000);
  endtask : t_erase
  task t_bursts;
    rd_burst(12'h000, 8'h80, 1'b1);
    rd_burst(12'h200, 8'h04, 1'b0);
    rd_burst(12'h300, 8'h01, 1'b0);
  endtask : t_bursts
  task t_wrap;
    apb(1'b1, 12'h010, 32'h00000002);
    rd_burst(12'h001, 8'h02, 1'b1);
    rd_burst(12'h001, 8'h04, 1'b0);
    apb(1'b1, 12'h010, 32'h00000006);
    rd_burst(12'h002, 8'h04, 1'b1);
    // serial with wrap bit set: length 3 only legal if incrementing
    apb(1'b1, 12'h010, 32'h00000003);
    rd_burst(12'h002, 8'h03, 1'b1);
    apb(1'b1, 12'h010, 32'h00000001);
    rd_burst(12'h010, 8'h20, 1'b1);
    apb(1'b1, 12'h00C, 32'h000000FF);
  endtask : t_wrap
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_erase;
    t_bursts;
    t_wrap;
    stop_test;
  end
  // run should end within about 5000 cycles
  initial begin
    #100000;
    n_mismatch++;
    stop_test;
  end
endmodule : fper_ctrl_tb
bind fper_ctrl fper_ctrl_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .cmd, .waitrequest, .rsp);
`default_nettype wire
